// [tb/seeb_bus_master.sv]
`timescale 1ns/1ps

// two-wire bus master; its clock stands high between frames
module seeb_bus_master #(
    parameter int unsigned HALF = 9
)
(
    // clock
    input wire logic clk,
    // bus
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // start, also usable as repeated start with clock low
    task automatic bus_start();
        tick(3);
        sda_low = 1'b0;
        tick(HALF - 3);
        scl = 1'b1;
        tick(HALF);
        sda_low = 1'b1;
        tick(HALF);
        scl = 1'b0;
    endtask

    task automatic bus_stop();
        tick(3);
        sda_low = 1'b1;
        tick(HALF - 3);
        scl = 1'b1;
        tick(HALF);
        sda_low = 1'b0;
        tick(HALF);
    endtask

    // data moves only while clock is low
    task automatic bus_bit(input logic b, output logic r);
        tick(3);
        sda_low = ~b;
        tick(HALF - 3);
        scl = 1'b1;
        tick(3);
        r = sda;
        tick(HALF - 3);
        scl = 1'b0;
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bus_bit(d[i], r);
        end
        bus_bit(1'b1, r);
        ack = ~r;
    endtask

    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bus_bit(1'b1, r);
            d[i] = r;
        end
        bus_bit(~ack, r);
    endtask
endmodule

// [tb/seeb_slave_bench.sv]
`timescale 1ns/1ps

module seeb_slave_bench;
    localparam int unsigned WCYC = 400;
    logic core_clk;
    logic rstn;
    logic inhibit;
    logic scl;
    logic m_low;
    logic sda_out;
    logic sda_oe;
    logic busy;
    wire logic sda;
    int errors;
    int compares;

    // open-drain wire, pulled up
    assign sda = (sda_oe ? sda_out : 1'b1) & ~m_low;

    seeb_slave #(.WRITE_CYCLES(WCYC)) dut_u (
        .CORE_CLK(core_clk), .RSTN(rstn), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .WRITE_INHIBIT(inhibit), .BUSY(busy));

    seeb_bus_master m_u (.clk(core_clk), .sda(sda), .scl(scl), .sda_low(m_low));

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic stop_test();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk_bit(input logic exp, input logic got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic chk_byte(input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // select plus address byte, then optional turn to read
    task automatic set_addr(input logic [10:0] a, input logic rd, output logic ak);
        logic k0;
        logic k1;
        m_u.bus_start();
        m_u.wr_byte({4'ha, a[10:8], 1'b0}, k0);
        m_u.wr_byte(a[7:0], k1);
        ak = k0 & k1;
        if (rd)
        begin
            m_u.bus_start();
            m_u.wr_byte({4'ha, a[10:8], 1'b1}, k0);
            ak = ak & k0;
        end
    endtask

    task automatic write_seq(input logic [10:0] a, input logic [7:0] d [0:3], input int n);
        logic ak;
        set_addr(a, 1'b0, ak);
        chk_bit(1'b1, ak);
        for (int i = 0; i < n; i++)
        begin
            m_u.wr_byte(d[i], ak);
            chk_bit(1'b1, ak);
        end
        m_u.bus_stop();
    endtask

    task automatic read_chk(input logic [10:0] a, input logic [7:0] e0, input logic [7:0] e1,
        input int n);
        logic ak;
        logic [7:0] d;
        set_addr(a, 1'b1, ak);
        chk_bit(1'b1, ak);
        m_u.rd_byte(n > 1, d);
        chk_byte(e0, d);
        if (n > 1)
        begin
            m_u.rd_byte(1'b0, d);
            chk_byte(e1, d);
        end
        m_u.bus_stop();
    endtask

    // bounded wait for the program cycle to end
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < WCYC + 40)
        begin
            m_u.tick(1);
            n++;
        end
        chk_bit(1'b0, busy);
    endtask

    task automatic t_reset();
        logic ak;
        logic [7:0] d;
        chk_bit(1'b0, busy);
        chk_bit(1'b0, sda_oe);
        m_u.bus_start();
        m_u.wr_byte(8'ha1, ak);
        chk_bit(1'b1, ak);
        m_u.rd_byte(1'b0, d);
        chk_byte(8'hff, d);
        m_u.bus_stop();
    endtask

    task automatic t_foreign();
        logic ak;
        m_u.bus_start();
        m_u.wr_byte(8'h50, ak);
        chk_bit(1'b0, ak);
        m_u.wr_byte(8'ha0, ak);
        chk_bit(1'b0, ak);
        m_u.bus_stop();
    endtask

    task automatic t_byte_write();
        logic ak;
        inhibit = 1'b0;
        write_seq(11'h000, '{8'h3c, 8'h00, 8'h00, 8'h00}, 1);
        m_u.tick(8);
        chk_bit(1'b1, busy);
        m_u.bus_start();
        m_u.wr_byte(8'ha0, ak);
        chk_bit(1'b0, ak);
        m_u.bus_stop();
        chk_bit(1'b1, busy);
        wait_idle();
        m_u.bus_start();
        m_u.wr_byte(8'ha0, ak);
        chk_bit(1'b1, ak);
        m_u.bus_stop();
        m_u.tick(10);
        chk_bit(1'b0, busy);
        read_chk(11'h000, 8'h3c, 8'h00, 1);
    endtask

    task automatic t_page();
        write_seq(11'h13e, '{8'ha1, 8'hb2, 8'hc3, 8'h00}, 3);
        m_u.tick(8);
        wait_idle();
        read_chk(11'h13e, 8'ha1, 8'hb2, 2);
        read_chk(11'h120, 8'hc3, 8'h00, 1);
        read_chk(11'h140, 8'hff, 8'h00, 1);
    endtask

    task automatic t_inhibit();
        inhibit = 1'b1;
        write_seq(11'h000, '{8'h99, 8'h00, 8'h00, 8'h00}, 1);
        m_u.tick(10);
        chk_bit(1'b0, busy);
        inhibit = 1'b0;
        read_chk(11'h000, 8'h3c, 8'h00, 1);
    endtask

    task automatic t_wrap();
        logic ak;
        logic r;
        logic [7:0] d;
        read_chk(11'h7ff, 8'hff, 8'h3c, 2);
        set_addr(11'h7ff, 1'b1, ak);
        m_u.rd_byte(1'b0, d);
        m_u.bus_bit(1'b1, r);
        chk_bit(1'b1, r);
        m_u.bus_stop();
        // stop while the master's answer bit is still due
        set_addr(11'h7ff, 1'b1, ak);
        for (int i = 0; i < 8; i++)
        begin
            m_u.bus_bit(1'b1, r);
        end
        m_u.bus_stop();
        chk_bit(1'b0, sda_oe);
    endtask

    // reset in mid-run, while a program cycle runs
    task automatic t_mid_reset();
        write_seq(11'h055, '{8'h5a, 8'h00, 8'h00, 8'h00}, 1);
        m_u.tick(8);
        chk_bit(1'b1, busy);
        rstn = 1'b0;
        m_u.tick(6);
        chk_bit(1'b0, busy);
        rstn = 1'b1;
        m_u.tick(6);
        chk_bit(1'b0, sda_oe);
        read_chk(11'h055, 8'hff, 8'hff, 2);
    endtask

    initial
    begin
        errors = 0;
        compares = 0;
        rstn = 1'b0;
        inhibit = 1'b0;
        repeat (6) @(negedge core_clk);
        rstn = 1'b1;
        m_u.tick(6);
        t_reset();
        t_foreign();
        t_byte_write();
        t_page();
        t_inhibit();
        t_wrap();
        t_mid_reset();
        stop_test();
    end

    // watchdog, well beyond the expected run of about 12000 cycles
    initial
    begin
        #480000;
        errors++;
        stop_test();
    end
endmodule

// [verilog/seeb_cfg.svh]
`ifndef SEEB_CFG_SVH
`define SEEB_CFG_SVH

// array geometry
`define SEEB_ADDR_W 11
`define SEEB_MEM_BYTES 2048
`define SEEB_BLOCK_W 3
`define SEEB_PAGE_BYTES 32
`define SEEB_PAGE_W 5
`define SEEB_ROW_W 6
`define SEEB_ERASED_BYTE 8'hff

// select byte layout
`define SEEB_TYPE_ID 4'ha
`define SEEB_TYPE_HI 7
`define SEEB_TYPE_LO 4
`define SEEB_BLK_HI 3
`define SEEB_BLK_LO 1
`define SEEB_RW_BIT 0

// serial framing
`define SEEB_BYTE_BITS 4'h8
`define SEEB_LAST_OUT_BIT 4'h7

// timing
`define SEEB_CLK_PERIOD_NS 8
`define SEEB_WRITE_TIME_NS 10000000
`define SEEB_WRITE_CYCLES (`SEEB_WRITE_TIME_NS / `SEEB_CLK_PERIOD_NS)

`endif

// [verilog/seeb_pkg.sv]
package seeb_pkg;

    typedef enum logic [3:0] {
        SEEB_IDLE      = 4'h0,
        SEEB_SELECT    = 4'h1,
        SEEB_SELECT_AK = 4'h2,
        SEEB_ADDR      = 4'h3,
        SEEB_ADDR_AK   = 4'h4,
        SEEB_WDATA     = 4'h5,
        SEEB_WDATA_AK  = 4'h6,
        SEEB_RDATA     = 4'h7,
        SEEB_RACK      = 4'h8,
        SEEB_PROG      = 4'h9
    } seeb_state_t;

endpackage

// [verilog/seeb_prog_timer.sv]
`timescale 1ns/1ps

// counts out the self-timed program cycle, one done pulse at the end
module seeb_prog_timer #(
    parameter int unsigned CYCLES = 1
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic start,
    output logic done
);

    logic [31:0] cnt_reg;
    logic run_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg <= 32'h0;
            run_reg <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start)
            begin
                cnt_reg <= 32'(CYCLES);
                run_reg <= 1'b1;
            end
            else if (run_reg)
            begin
                if (cnt_reg <= 32'h1)
                begin
                    run_reg <= 1'b0;
                    done <= 1'b1;
                end
                else
                begin
                    cnt_reg <= cnt_reg - 32'h1;
                end
            end
        end
    end

endmodule

// [verilog/seeb_slave.sv]
`timescale 1ns/1ps
`include "seeb_cfg.svh"

// What this block does
// R1: data rising while clock high is stop
// R2: stop after read returns to idle
// R3: stop after write starts programming
// R4: receiver pulls data low on ninth clock
// R5: sample data on clock rising edge
// R6: master changes data only while clock low
// R7: select byte is seven-bit code plus direction
// R8: answer only when upper nibble is 1010
// R9: bits 5-7 block, bit 8 direction, ack
// R10: write takes acknowledged eight-bit byte address
// R11: write inhibit high leaves array unchanged
// R12: byte write needs no mode pin
// R13: page write takes up to 32 bytes
// R14: page write increments low five bits only
// R15: programming ignores bus, no answers
// R16: busy withholds ack, ready acks poll
// R17: array starts with every byte ff
// R18: current read sends byte, then increments
// R19: random read is dummy write then read
// R20: master ack makes next byte follow
// R21: read address wraps past last byte
// R22: no ack on ninth bit ends read
// R23: data falling while clock high is start
// R24: nothing answered until a start
// R25: busy clears after configured write count
module seeb_slave #(
    parameter int unsigned WRITE_CYCLES = `SEEB_WRITE_CYCLES
)
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    // two-wire bus
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    // control and status
    input wire logic WRITE_INHIBIT,
    output logic BUSY
);

    seeb_pkg::seeb_state_t state_reg;
    logic scl_s1, scl_s2, scl_d;
    logic sda_s1, sda_s2, sda_d;
    logic wi_s1, wi_s2;
    logic scl_rise, scl_fall, start_det, stop_det;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [`SEEB_ADDR_W-1:0] addr_reg;
    logic [`SEEB_ROW_W-1:0] row_address_bits_reg;
    logic rw_reg;
    logic have_data_reg;
    logic mack_reg;
    logic busy_reg;
    logic sda_oe_reg;
    logic sda_out_reg;
    logic commit;
    logic prog_done;
    logic byte_in_done;
    logic id_match;
    logic page_wr;
    logic page_clr;
    logic [7:0] rd_byte;
    logic [7:0] mem [`SEEB_MEM_BYTES];
    logic [7:0] page_data [`SEEB_PAGE_BYTES];
    logic [`SEEB_PAGE_BYTES-1:0] page_vld;

    // two-stage synchronisers, then one delay stage for edges
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d <= 1'b1;
            wi_s1 <= 1'b0;
            wi_s2 <= 1'b0;
        end
        else
        begin
            scl_s1 <= SCL_IN;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= SDA_IN;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
            wi_s1 <= WRITE_INHIBIT;
            wi_s2 <= wi_s1;
        end
    end

    always_comb
    begin
        scl_rise = scl_s2 & ~scl_d;
        scl_fall = ~scl_s2 & scl_d;
        start_det = scl_s2 & scl_d & sda_d & ~sda_s2; // [R23]
        stop_det = scl_s2 & scl_d & ~sda_d & sda_s2; // [R1]
        byte_in_done = scl_fall & (bit_cnt_reg == `SEEB_BYTE_BITS);
        id_match = (shift_reg[`SEEB_TYPE_HI:`SEEB_TYPE_LO] == `SEEB_TYPE_ID); // [R8]
        page_wr = (state_reg == seeb_pkg::SEEB_WDATA) & byte_in_done;
        page_clr = (state_reg == seeb_pkg::SEEB_ADDR) & byte_in_done;
        // only a write that latched data and is not inhibited programs
        commit = stop_det & (state_reg != seeb_pkg::SEEB_PROG) & have_data_reg
            & ~wi_s2; // [R3] [R11] [R12]
        rd_byte = mem[addr_reg];
    end

    seeb_prog_timer #(
        .CYCLES(WRITE_CYCLES)
    ) u_prog_timer (
        .clk(CORE_CLK),
        .rst_n(RSTN),
        .start(commit),
        .done(prog_done)
    );

    // protocol engine
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            state_reg <= seeb_pkg::SEEB_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            addr_reg <= '0;
            row_address_bits_reg <= '0;
            rw_reg <= 1'b0;
            mack_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end
        else if (state_reg == seeb_pkg::SEEB_PROG)
        begin
            // bus ignored until the write time runs out
            sda_oe_reg <= 1'b0; // [R15]
            if (prog_done)
            begin
                state_reg <= seeb_pkg::SEEB_IDLE; // [R25] [R16]
            end
        end
        else if (commit)
        begin
            state_reg <= seeb_pkg::SEEB_PROG; // [R3]
            sda_oe_reg <= 1'b0;
        end
        else if (stop_det)
        begin
            state_reg <= seeb_pkg::SEEB_IDLE; // [R2]
            sda_oe_reg <= 1'b0;
        end
        else if (start_det)
        begin
            state_reg <= seeb_pkg::SEEB_SELECT; // [R24]
            bit_cnt_reg <= 4'h0;
            sda_oe_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                seeb_pkg::SEEB_SELECT, seeb_pkg::SEEB_ADDR, seeb_pkg::SEEB_WDATA:
                begin
                    if (scl_rise)
                    begin
                        shift_reg <= {shift_reg[6:0], sda_s2}; // [R5] [R7]
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    else if (byte_in_done)
                    begin
                        bit_cnt_reg <= 4'h0;
                        if (state_reg == seeb_pkg::SEEB_SELECT)
                        begin
                            if (id_match)
                            begin
                                sda_oe_reg <= 1'b1; // [R9] [R4]
                                rw_reg <= shift_reg[`SEEB_RW_BIT];
                                addr_reg[`SEEB_ADDR_W-1:8] <=
                                    shift_reg[`SEEB_BLK_HI:`SEEB_BLK_LO];
                                state_reg <= seeb_pkg::SEEB_SELECT_AK;
                            end
                            else
                            begin
                                state_reg <= seeb_pkg::SEEB_IDLE; // [R8]
                            end
                        end
                        else if (state_reg == seeb_pkg::SEEB_ADDR)
                        begin
                            addr_reg[7:0] <= shift_reg; // [R10] [R19]
                            row_address_bits_reg <=
                                {addr_reg[`SEEB_ADDR_W-1:8], shift_reg[7:5]};
                            sda_oe_reg <= 1'b1; // [R10]
                            state_reg <= seeb_pkg::SEEB_ADDR_AK;
                        end
                        else
                        begin
                            // wrap inside the page
                            addr_reg[`SEEB_PAGE_W-1:0] <=
                                addr_reg[`SEEB_PAGE_W-1:0] + 5'h01; // [R14]
                            sda_oe_reg <= 1'b1; // [R13]
                            state_reg <= seeb_pkg::SEEB_WDATA_AK;
                        end
                    end
                end
                seeb_pkg::SEEB_SELECT_AK:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_reg <= 4'h0;
                        if (rw_reg)
                        begin
                            shift_reg <= rd_byte; // [R18]
                            sda_oe_reg <= ~rd_byte[7];
                            state_reg <= seeb_pkg::SEEB_RDATA;
                        end
                        else
                        begin
                            sda_oe_reg <= 1'b0; // [R4]
                            state_reg <= seeb_pkg::SEEB_ADDR;
                        end
                    end
                end
                seeb_pkg::SEEB_ADDR_AK, seeb_pkg::SEEB_WDATA_AK:
                begin
                    if (scl_fall)
                    begin
                        sda_oe_reg <= 1'b0;
                        bit_cnt_reg <= 4'h0;
                        state_reg <= seeb_pkg::SEEB_WDATA;
                    end
                end
                seeb_pkg::SEEB_RDATA:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_reg == `SEEB_LAST_OUT_BIT)
                        begin
                            sda_oe_reg <= 1'b0; // [R4]
                            addr_reg <= addr_reg + 11'h001; // [R18] [R21]
                            state_reg <= seeb_pkg::SEEB_RACK;
                        end
                        else
                        begin
                            shift_reg <= {shift_reg[6:0], 1'b1};
                            sda_oe_reg <= ~shift_reg[6];
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                    end
                end
                seeb_pkg::SEEB_RACK:
                begin
                    if (scl_rise)
                    begin
                        mack_reg <= ~sda_s2;
                    end
                    else if (scl_fall)
                    begin
                        bit_cnt_reg <= 4'h0;
                        if (mack_reg)
                        begin
                            shift_reg <= rd_byte; // [R20]
                            sda_oe_reg <= ~rd_byte[7];
                            state_reg <= seeb_pkg::SEEB_RDATA;
                        end
                        else
                        begin
                            state_reg <= seeb_pkg::SEEB_IDLE; // [R22]
                        end
                    end
                end
                seeb_pkg::SEEB_IDLE:
                begin
                    sda_oe_reg <= 1'b0;
                end
                default:
                begin
                    state_reg <= seeb_pkg::SEEB_IDLE;
                    sda_oe_reg <= 1'b0;
                end
            endcase
        end
    end

    // latched write data waiting for stop
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            have_data_reg <= 1'b0;
        end
        else if (page_wr)
        begin
            have_data_reg <= 1'b1;
        end
        else if (stop_det | start_det | page_clr)
        begin
            have_data_reg <= 1'b0;
        end
    end

    generate
        for (genvar i = 0; i < `SEEB_PAGE_BYTES; i++)
        begin : g_page
            always_ff @(posedge CORE_CLK or negedge RSTN)
            begin
                if (!RSTN)
                begin
                    page_data[i] <= 8'h00;
                    page_vld[i] <= 1'b0;
                end
                else if (page_wr && (addr_reg[`SEEB_PAGE_W-1:0] == 5'(i)))
                begin
                    page_data[i] <= shift_reg; // [R13]
                    page_vld[i] <= 1'b1;
                end
                else if (page_clr | stop_det)
                begin
                    page_vld[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // array, erased at reset, written once per program cycle
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            for (int k = 0; k < `SEEB_MEM_BYTES; k++)
            begin
                mem[k] <= `SEEB_ERASED_BYTE; // [R17]
            end
        end
        else if (commit)
        begin
            for (int k = 0; k < `SEEB_PAGE_BYTES; k++)
            begin
                if (page_vld[k])
                begin
                    mem[{row_address_bits_reg, 5'(k)}] <= page_data[k]; // [R13]
                end
            end
        end
    end

    // pin and status outputs
    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            busy_reg <= 1'b0;
            sda_out_reg <= 1'b0;
        end
        else
        begin
            busy_reg <= commit | (busy_reg & ~prog_done); // [R25]
            sda_out_reg <= 1'b0;
        end
    end

    assign SDA_OE = sda_oe_reg;
    assign SDA_OUT = sda_out_reg;
    assign BUSY = busy_reg;

    property p_stop_read;
        @(posedge CORE_CLK) disable iff (!RSTN)
        stop_det && (state_reg == seeb_pkg::SEEB_RDATA || state_reg == seeb_pkg::SEEB_RACK)
        |=> state_reg == seeb_pkg::SEEB_IDLE && !SDA_OE;
    endproperty
    a_stop_read: assert property (p_stop_read) else $error("read not ended by stop"); // [R2]

    property p_stop_write;
        @(posedge CORE_CLK) disable iff (!RSTN)
        stop_det && have_data_reg && !wi_s2 && state_reg != seeb_pkg::SEEB_PROG
        |=> state_reg == seeb_pkg::SEEB_PROG ##1 BUSY;
    endproperty
    a_stop_write: assert property (p_stop_write) else $error("write stop did not program"); // [R3]

    property p_id_ack;
        @(posedge CORE_CLK) disable iff (!RSTN)
        state_reg == seeb_pkg::SEEB_SELECT && byte_in_done && !start_det && !stop_det
        |=> SDA_OE == $past(id_match);
    endproperty
    a_id_ack: assert property (p_id_ack) else $error("select ack wrong"); // [R8]

    property p_prog_quiet;
        @(posedge CORE_CLK) disable iff (!RSTN)
        state_reg == seeb_pkg::SEEB_PROG |=> !SDA_OE;
    endproperty
    a_prog_quiet: assert property (p_prog_quiet) else $error("answer while programming"); // [R15]

    property p_inhibit;
        @(posedge CORE_CLK) disable iff (!RSTN)
        stop_det && wi_s2 && state_reg != seeb_pkg::SEEB_PROG
        |=> state_reg != seeb_pkg::SEEB_PROG;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibited write programmed"); // [R11]

    property p_nack_end;
        @(posedge CORE_CLK) disable iff (!RSTN)
        state_reg == seeb_pkg::SEEB_RACK && scl_fall && !mack_reg && !start_det && !stop_det
        |=> state_reg == seeb_pkg::SEEB_IDLE [*2];
    endproperty
    a_nack_end: assert property (p_nack_end) else $error("read went on after nack"); // [R22]

    property p_page_wrap;
        @(posedge CORE_CLK) disable iff (!RSTN)
        page_wr && !start_det && !stop_det
        |=> addr_reg[4:0] == $past(addr_reg[4:0]) + 5'h01
            && addr_reg[10:5] == $past(addr_reg[10:5]);
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("page counter step wrong"); // [R14]

    property p_read_inc;
        @(posedge CORE_CLK) disable iff (!RSTN)
        state_reg == seeb_pkg::SEEB_RDATA && scl_fall && bit_cnt_reg == 4'h7
            && !start_det && !stop_det
        |=> addr_reg == $past(addr_reg) + 11'h001;
    endproperty
    a_read_inc: assert property (p_read_inc) else $error("read address not advanced"); // [R21]

    property p_busy_end;
        @(posedge CORE_CLK) disable iff (!RSTN)
        state_reg == seeb_pkg::SEEB_PROG && prog_done
        |=> state_reg == seeb_pkg::SEEB_IDLE ##0 !BUSY;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy did not clear"); // [R25]

endmodule
